/* File: nsli_led_obs.sv */
// Purpose: operator view of the two leds
// Assumes: leds sampled on clk_i
// Notes:   counters run free, the bench takes differences
`timescale 1ns/1ps
module nsli_led_obs (
    // leds
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic err_i,
    // on-time and edge counts
    output int        run_on_o = 0,
    output int        run_ed_o = 0,
    output int        err_on_o = 0,
    output int        err_ed_o = 0
);
    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    logic run_q = 1'b0;
    logic err_q = 1'b0;
    // every sample counts, so times come out in clock cycles
    always @(posedge clk_i) begin
        run_on_o <= run_on_o + int'(run_i);
        run_ed_o <= run_ed_o + int'(run_i != run_q);
        err_on_o <= err_on_o + int'(err_i);
        err_ed_o <= err_ed_o + int'(err_i != err_q);
        run_q    <= run_i;
        err_q    <= err_i;
    end
endmodule : nsli_led_obs

/* File: nsli_pattern.sv */
// Purpose: one led pattern generator from shared slot phase
// Assumes: slot phase counters from the top
// Notes:   dbl_i low or high selects single or double flash
`timescale 1ns/1ps
module nsli_pattern
    import nsli_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // pattern select
    input  wire nsli_pat_e  pat_i,
    input  wire logic       dbl_i,
    // phase
    input  wire logic       flick_ph_i,
    input  wire logic       blink_ph_i,
    input  wire logic [4:0] flash_ph_i,
    // led
    output logic            led_o
);
    wire single_on = (flash_ph_i < 5'h4);
    wire double_on = single_on || (flash_ph_i >= 5'h8 && flash_ph_i < 5'hc);
    wire flash_on  = dbl_i ? double_on : single_on;
    logic led_nxt;

    always_comb begin
        unique case (pat_i)
            NSLI_PAT_OFF:   led_nxt = 1'b0;
            NSLI_PAT_ON:    led_nxt = 1'b1;
            NSLI_PAT_BLINK: led_nxt = blink_ph_i;
            NSLI_PAT_FLICK: led_nxt = flick_ph_i;
            NSLI_PAT_FLASH: led_nxt = flash_on;
            default:        led_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) led_o <= 1'b0;
        else       led_o <= led_nxt;
    end
endmodule : nsli_pattern

/* File: nsli_pkg.sv */
// Purpose: types for the network state led indicator
// Assumes: nsli_regs.svh constants
// Notes:   none
package nsli_pkg;
    typedef enum logic [4:0] {
        NSLI_PAT_OFF    = 5'b00001,
        NSLI_PAT_ON     = 5'b00010,
        NSLI_PAT_BLINK  = 5'b00100,
        NSLI_PAT_FLICK  = 5'b01000,
        NSLI_PAT_FLASH  = 5'b10000
    } nsli_pat_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } nsli_wb_req_s;
endpackage : nsli_pkg

/* File: nsli_regs.svh */
// Purpose: constants for the network state led indicator
// Assumes: 250 MHz system clock
// Notes:   offsets are word byte addresses on the register bus
`ifndef NSLI_REGS_SVH
`define NSLI_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NSLI_OFS_STATE    8'h00
`define NSLI_OFS_ERROR    8'h04
`define NSLI_OFS_ALIAS    8'h08
`define NSLI_OFS_POSADDR  8'h0c
`define NSLI_OFS_IRQ_STAT 8'h10
`define NSLI_OFS_IRQ_MASK 8'h14
`define NSLI_OFS_LEDS     8'h18

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define NSLI_STATE_W      4
`define NSLI_ST_INIT      4'h1
`define NSLI_ST_PREOP     4'h2
`define NSLI_ST_BOOT      4'h3
`define NSLI_ST_SAFEOP    4'h4
`define NSLI_ST_OP        4'h8
`define NSLI_CHANGE_BIT   4
`define NSLI_BOOTING_BIT  5
`define NSLI_FWDL_BIT     6
`define NSLI_CHANGE_FLAG  1'h1
`define NSLI_ERR_PDI      0
`define NSLI_ERR_CFG      1
`define NSLI_ERR_BOOT     2
`define NSLI_ERR_APPWD    3
`define NSLI_ERR_W        4
`define NSLI_ALIAS_RST    16'h0000
`define NSLI_IRQ_W        5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NSLI_CLK_HZ       250000000
`define NSLI_T_SLOT_MS    50
`define NSLI_SLOT_CYC     (`NSLI_CLK_HZ / 1000 * `NSLI_T_SLOT_MS)
`define NSLI_T_SHORT_MS   200
`define NSLI_T_LONG_MS    1000
`define NSLI_SHORT_SLOTS  (`NSLI_T_SHORT_MS / `NSLI_T_SLOT_MS)
`define NSLI_LONG_SLOTS   (`NSLI_T_LONG_MS / `NSLI_T_SLOT_MS)

`endif

/* File: nsli_top.sv */
// Purpose: network run and error indicator led pattern generator
// Assumes: 250 MHz clk_i, synchronous reset, classic wishbone slave
// Notes:   state and error inputs come from same-clock slave logic
`timescale 1ns/1ps
`include "nsli_regs.svh"
module nsli_top
    import nsli_pkg::*;
#(
    parameter int SLOT_CYC = `NSLI_SLOT_CYC
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // network slave state
    input  wire logic [3:0]  net_state_i,
    input  wire logic        net_change_i,
    input  wire logic        net_booting_i,
    input  wire logic        fw_download_i,
    input  wire logic [3:0]  net_err_i,
    // station addressing
    input  wire logic        net_alias_we_i,
    input  wire logic [15:0] net_alias_i,
    input  wire logic        pos_addr_we_i,
    input  wire logic [15:0] pos_addr_i,
    output logic [15:0]      station_alias_o,
    output logic [15:0]      pos_addr_o,
    // leds and interrupt
    output logic             network_run_indicator_o,
    output logic             error_led_o,
    output logic             irq_o
);
    if (SLOT_CYC < 2) begin : g_bad_slot
        $error("SLOT_CYC must be at least 2");
    end

    // ----------------------------------------------------------------
    // slot timebase
    // ----------------------------------------------------------------
    // one 50 ms slot; every pattern is a whole number of slots
    logic [31:0] slot_cnt_r;
    logic        flick_r;
    logic [1:0]  blink_cnt_r;
    logic        blink_r;
    logic [4:0]  flash_ph_r;
    logic [4:0]  dbl_ph_r;
    wire         slot_end  = (slot_cnt_r == 32'(SLOT_CYC - 1));
    wire         blink_end = (blink_cnt_r == 2'(`NSLI_SHORT_SLOTS - 1));
    // single flash: 200 on, 1000 off
    wire         flash_end = (flash_ph_r == 5'(`NSLI_SHORT_SLOTS + `NSLI_LONG_SLOTS - 1));
    // double flash: 200 on, 200 off, 200 on, 1000 off
    wire         dbl_end   = (dbl_ph_r == 5'(3 * `NSLI_SHORT_SLOTS + `NSLI_LONG_SLOTS - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt_r  <= 32'h0;
            flick_r     <= 1'b1;
            blink_cnt_r <= 2'h0;
            blink_r     <= 1'b1;
            flash_ph_r  <= 5'h0;
            dbl_ph_r    <= 5'h0;
        end else begin
            slot_cnt_r <= slot_end ? 32'h0 : slot_cnt_r + 32'h1;
            if (slot_end) begin
                flick_r     <= ~flick_r;
                blink_cnt_r <= blink_end ? 2'h0 : blink_cnt_r + 2'h1;
                if (blink_end) blink_r <= ~blink_r;
                flash_ph_r  <= flash_end ? 5'h0 : flash_ph_r + 5'h1;
                dbl_ph_r    <= dbl_end ? 5'h0 : dbl_ph_r + 5'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // pattern selection
    // ----------------------------------------------------------------
    wire st_init   = (net_state_i == `NSLI_ST_INIT);
    wire st_preop  = (net_state_i == `NSLI_ST_PREOP);
    wire st_boot   = (net_state_i == `NSLI_ST_BOOT);
    wire st_safeop = (net_state_i == `NSLI_ST_SAFEOP);
    wire st_op     = (net_state_i == `NSLI_ST_OP);
    wire chg       = (net_change_i == `NSLI_CHANGE_FLAG);

    nsli_pat_e run_pat;
    nsli_pat_e err_pat;
    logic      err_dbl;

    always_comb begin
        if (fw_download_i || net_booting_i || st_boot)
            run_pat = NSLI_PAT_FLICK;
        else if (st_op)
            run_pat = NSLI_PAT_ON;
        else if (st_preop)
            run_pat = NSLI_PAT_BLINK;
        else if (st_safeop)
            run_pat = NSLI_PAT_FLASH;
        else
            run_pat = NSLI_PAT_OFF;
    end

    // priority: most severe error shown when several are flagged
    always_comb begin
        err_dbl = 1'b0;
        if (net_err_i[`NSLI_ERR_PDI])
            err_pat = NSLI_PAT_ON;
        else if (net_err_i[`NSLI_ERR_BOOT] && st_init && chg)
            err_pat = NSLI_PAT_FLICK;
        else if (net_err_i[`NSLI_ERR_APPWD]) begin
            err_pat = NSLI_PAT_FLASH;
            err_dbl = 1'b1;
        end else if (net_err_i[`NSLI_ERR_CFG])
            err_pat = NSLI_PAT_BLINK;
        else if (chg)
            err_pat = NSLI_PAT_FLASH;
        else
            err_pat = NSLI_PAT_OFF;
    end

    // periods differ, so the double flash keeps a phase of its own
    wire [4:0] err_flash_ph = err_dbl ? dbl_ph_r : flash_ph_r;

    nsli_pattern u_run (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pat_i      (run_pat),
        .dbl_i      (1'b0),
        .flick_ph_i (flick_r),
        .blink_ph_i (blink_r),
        .flash_ph_i (flash_ph_r),
        .led_o      (network_run_indicator_o)
    );

    nsli_pattern u_err (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pat_i      (err_pat),
        .dbl_i      (err_dbl),
        .flick_ph_i (flick_r),
        .blink_ph_i (blink_r),
        .flash_ph_i (err_flash_ph),
        .led_o      (error_led_o)
    );

    // ----------------------------------------------------------------
    // wishbone decode
    // ----------------------------------------------------------------
    wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wb_wr   = wb_req && wb_we_i;
    wire        sel_lo  = wb_sel_i[0];
    wire        sel_hi  = wb_sel_i[1];
    wire        hit_al  = (wb_adr_i == `NSLI_OFS_ALIAS);
    wire        hit_ist = (wb_adr_i == `NSLI_OFS_IRQ_STAT);
    wire        hit_msk = (wb_adr_i == `NSLI_OFS_IRQ_MASK);
    wire [15:0] sw_alias = {sel_hi ? wb_dat_i[15:8] : station_alias_o[15:8],
                            sel_lo ? wb_dat_i[7:0]  : station_alias_o[7:0]};

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    // bits: pdi wd, cfg err, boot err, app wd, state change
    logic [4:0] ev_prev_r;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_mask_r;
    wire  [4:0] ev_now  = {st_init ? 1'b0 : chg, net_err_i};
    wire  [4:0] ev_rise = ev_now & ~ev_prev_r;
    wire  [4:0] ist_clr = (wb_wr && hit_ist && sel_lo) ? wb_dat_i[4:0] : 5'h0;
    wire  [4:0] ist_nxt = (irq_stat_r & ~ist_clr) | ev_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_prev_r  <= 5'h0;
            irq_stat_r <= 5'h0;
            irq_mask_r <= 5'h0;
            irq_o      <= 1'b0;
        end else begin
            ev_prev_r  <= ev_now;
            irq_stat_r <= ist_nxt;
            if (wb_wr && hit_msk && sel_lo) irq_mask_r <= wb_dat_i[4:0];
            irq_o      <= |(ist_nxt & irq_mask_r);
        end
    end

    // ----------------------------------------------------------------
    // station addressing
    // ----------------------------------------------------------------
    // software write wins over a network write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            station_alias_o <= `NSLI_ALIAS_RST;
            pos_addr_o      <= 16'h0000;
        end else begin
            if (wb_wr && hit_al)
                station_alias_o <= sw_alias;
            else if (net_alias_we_i)
                station_alias_o <= net_alias_i;
            if (pos_addr_we_i)
                pos_addr_o <= pos_addr_i;
        end
    end

    // ----------------------------------------------------------------
    // read mux and ack
    // ----------------------------------------------------------------
    logic [31:0] rd_data;
    always_comb begin
        unique case (wb_adr_i)
            `NSLI_OFS_STATE:    rd_data = {25'h0, fw_download_i, net_booting_i,
                                           net_change_i, net_state_i};
            `NSLI_OFS_ERROR:    rd_data = {28'h0, net_err_i};
            `NSLI_OFS_ALIAS:    rd_data = {16'h0, station_alias_o};
            `NSLI_OFS_POSADDR:  rd_data = {16'h0, pos_addr_o};
            `NSLI_OFS_IRQ_STAT: rd_data = {27'h0, irq_stat_r};
            `NSLI_OFS_IRQ_MASK: rd_data = {27'h0, irq_mask_r};
            `NSLI_OFS_LEDS:     rd_data = {30'h0, error_led_o, network_run_indicator_o};
            default:            rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h0;
        end
    end
endmodule : nsli_top

/* File: nsli_top_properties.sv */
// Purpose: port checks for nsli_top
// Assumes: one clock, sync active-high reset
// Notes:   three cycles of input history cover led latency
`timescale 1ns/1ps
`include "nsli_regs.svh"
module nsli_top_chk
    import nsli_pkg::*;
#(
    parameter int SLOT_CYC = 10
)(
    // clock and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // state, leds, irq
    input wire logic [3:0]  net_state_i,
    input wire logic        net_change_i,
    input wire logic        net_booting_i,
    input wire logic        fw_download_i,
    input wire logic [3:0]  net_err_i,
    input wire logic        network_run_indicator_o,
    input wire logic        error_led_o,
    input wire logic        irq_o
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic quiet   = !fw_download_i && !net_booting_i;
    wire logic in_init = net_state_i == `NSLI_ST_INIT && quiet;
    wire logic in_op   = net_state_i == `NSLI_ST_OP && quiet;
    wire logic no_err  = net_err_i == 4'h0 && !net_change_i;
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("request not acked next cycle");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    // reset itself must be watched, so no disable here
    property p_rst;
        disable iff (1'b0) rst_i |=> !(wb_ack_o || irq_o || error_led_o || network_run_indicator_o);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    property p_run_init;
        (in_init)[*3] |=> !network_run_indicator_o;
    endproperty
    a_run_init: assert property (p_run_init) else $error("run led lit in init");
    property p_run_op;
        (in_op)[*3] |=> network_run_indicator_o;
    endproperty
    a_run_op: assert property (p_run_op) else $error("run led dark in op");
    property p_fw_flick;
        fw_download_i[*3] ##0 $rose(network_run_indicator_o)
            |-> ##SLOT_CYC (!network_run_indicator_o || !fw_download_i);
    endproperty
    a_fw_flick: assert property (p_fw_flick) else $error("no flicker in download");
    property p_err_pdi;
        net_err_i[0][*3] |=> error_led_o;
    endproperty
    a_err_pdi: assert property (p_err_pdi) else $error("red led dark on pdi timeout");
    property p_err_dark;
        (no_err)[*3] |=> !error_led_o;
    endproperty
    a_err_dark: assert property (p_err_dark) else $error("red led lit without error");
    c_safe: cover property (net_state_i == `NSLI_ST_SAFEOP ##1 $rose(network_run_indicator_o));
    c_dbl: cover property (net_err_i[3] && $rose(error_led_o));
    c_irq: cover property ($rose(irq_o));
endmodule : nsli_top_chk

bind nsli_top nsli_top_chk #(.SLOT_CYC(SLOT_CYC)) u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .net_state_i,
    .net_change_i, .net_booting_i, .fw_download_i, .net_err_i,
    .network_run_indicator_o, .error_led_o, .irq_o);

/* File: tb_network_state_led_indicator.sv */
// Purpose: self-checking bench for nsli_top
// Assumes: slot shortened to 10 cycles
// Notes:   led timing judged by on-time and edges per window
`timescale 1ns/1ps
`include "nsli_regs.svh"
module tb_network_state_led_indicator
    import nsli_pkg::*;
;
    // ----------------------------------------------------------------
    // signals, design, observer
    // ----------------------------------------------------------------
    localparam int SC  = 10;
    localparam int WIN = 96 * SC; // whole periods of every pattern
    typedef struct {
        logic [10:0] in;
        int          ron, red, eon, eed;
    } nsli_row_s;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    nsli_wb_req_s req   = '0;
    logic [3:0]   net_state_i = 4'h0, net_err_i = 4'h0;
    logic         net_change_i = 1'b0, net_booting_i = 1'b0, fw_download_i = 1'b0;
    logic         net_alias_we_i = 1'b0, pos_addr_we_i = 1'b0;
    logic [15:0]  net_alias_i = 16'h0, pos_addr_i = 16'h0;
    logic [31:0]  wb_dat_o, rd;
    logic [15:0]  station_alias_o, pos_addr_o;
    logic         wb_ack_o, network_run_indicator_o, error_led_o, irq_o;
    int           ron, red, eon, eed, errors = 0, checked = 0;
    int           s [4];
    nsli_row_s    rows [14] = '{
        '{{4'h1, 3'b000, 4'h0}, 0, 0, 0, 0},
        '{{4'h8, 3'b000, 4'h0}, WIN, 0, 0, 0},
        '{{4'h2, 3'b000, 4'h0}, WIN / 2, 24, 0, 0},
        '{{4'h4, 3'b000, 4'h0}, WIN / 6, 8, 0, 0},
        '{{4'h3, 3'b000, 4'h0}, WIN / 2, 96, 0, 0},
        '{{4'h0, 3'b010, 4'h0}, WIN / 2, 96, 0, 0},
        '{{4'h8, 3'b001, 4'h0}, WIN / 2, 96, 0, 0},
        '{{4'h1, 3'b001, 4'h1}, WIN / 2, 96, WIN, 0},
        '{{4'h8, 3'b000, 4'h2}, WIN, 0, WIN / 2, 24},
        '{{4'h1, 3'b100, 4'h4}, 0, 0, WIN / 2, 96},
        '{{4'h8, 3'b100, 4'h4}, WIN, 0, WIN / 6, 8},
        '{{4'h4, 3'b100, 4'h0}, WIN / 6, 8, WIN / 6, 8},
        '{{4'h8, 3'b000, 4'ha}, WIN, 0, WIN / 4, 12},
        '{{4'h1, 3'b100, 4'hf}, 0, 0, WIN, 0}};
    always #2 clk_i = ~clk_i;
    nsli_top #(.SLOT_CYC(SC)) dut (
        .clk_i, .rst_i, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o,
        .wb_ack_o, .net_state_i, .net_change_i, .net_booting_i, .fw_download_i,
        .net_err_i, .net_alias_we_i, .net_alias_i, .pos_addr_we_i, .pos_addr_i,
        .station_alias_o, .pos_addr_o, .network_run_indicator_o, .error_led_o, .irq_o);
    nsli_led_obs u_obs (.clk_i, .run_i(network_run_indicator_o), .err_i(error_led_o),
        .run_on_o(ron), .run_ed_o(red), .err_on_o(eon), .err_ed_o(eed));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        // no local limit: only the watchdog ends a wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        req <= '0;
        @(posedge clk_i);
    endtask : wb
    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_i);
            {net_state_i, net_change_i, net_booting_i, fw_download_i, net_err_i} <= rows[i].in;
            repeat (5) @(posedge clk_i);
            wb(1'b0, `NSLI_OFS_ERROR, 32'h0);
            chk("err reg", rd, {28'h0, rows[i].in[3:0]});
            s = '{ron, red, eon, eed};
            repeat (WIN) @(posedge clk_i);
            chk("run on", ron - s[0], rows[i].ron);
            chk("run edges", red - s[1], rows[i].red);
            chk("err on", eon - s[2], rows[i].eon);
            chk("err edges", eed - s[3], rows[i].eed);
            $display("row %0d done", i);
        end
        // alias from bus then network, position address read-only
        wb(1'b1, `NSLI_OFS_ALIAS, 32'ha5c3);
        chk("alias bus", station_alias_o, 32'ha5c3);
        net_alias_i <= 16'h1234;
        net_alias_we_i <= 1'b1;
        pos_addr_i <= 16'h0042;
        pos_addr_we_i <= 1'b1;
        @(posedge clk_i);
        net_alias_we_i <= 1'b0;
        pos_addr_we_i <= 1'b0;
        @(posedge clk_i);
        chk("alias net", station_alias_o, 32'h1234);
        wb(1'b1, `NSLI_OFS_POSADDR, 32'hffff);
        wb(1'b0, `NSLI_OFS_POSADDR, 32'h0);
        chk("pos addr", rd, 32'h0042);
        chk("pos addr pin", pos_addr_o, 32'h0042);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("address test done");
        // events, mask and write-one-to-clear
        net_err_i <= 4'h0;
        net_change_i <= 1'b0;
        wb(1'b1, `NSLI_OFS_IRQ_MASK, 32'h1);
        wb(1'b1, `NSLI_OFS_IRQ_STAT, 32'h1f);
        wb(1'b0, `NSLI_OFS_IRQ_STAT, 32'h0);
        chk("stat clear", rd, 32'h0);
        chk("irq idle", irq_o, 1'b0);
        net_err_i <= 4'h3;
        repeat (4) @(posedge clk_i);
        chk("irq set", irq_o, 1'b1);
        wb(1'b1, `NSLI_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq masked", irq_o, 1'b0);
        wb(1'b0, `NSLI_OFS_IRQ_STAT, 32'h0);
        chk("stat left", rd, 32'h2);
        wb(1'b0, `NSLI_OFS_IRQ_MASK, 32'h0);
        chk("mask read", rd, 32'h1);
        wb(1'b0, `NSLI_OFS_STATE, 32'h0);
        chk("state reg", rd, 32'h1);
        wb(1'b0, `NSLI_OFS_LEDS, 32'h0);
        chk("leds reg", rd, 32'h2);
        $display("irq test done");
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("reset leds", {network_run_indicator_o, error_led_o, irq_o}, 3'b000);
        rst_i <= 1'b0;
        wb(1'b0, `NSLI_OFS_ALIAS, 32'h0);
        chk("alias reset", rd, {16'h0, `NSLI_ALIAS_RST});
        $display("reset test done");
        final_report();
    end
    // hang guard: well beyond all rows and bus tests
    initial begin
        repeat (20 * WIN) @(posedge clk_i);
        errors++;
        final_report();
    end
endmodule : tb_network_state_led_indicator
